// ===== logic/psp_map.svh
// register fields, reset values and widths of the parallel slave port
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
`define PSP_DATA_W      8
`define PSP_FIFO_DEPTH  8
`define PSP_CTL_MODE    4
`define PSP_CTL_OVF     5
`define PSP_CTL_OBF     6
`define PSP_CTL_IBF     7
`define PSP_CTL_RESET   8'h00
`define PSP_DIR_RD      0
`define PSP_DIR_WR      1
`define PSP_DIR_CS      2
`endif

// ===== logic/psp_pkg.sv
// types of the parallel slave port
package psp_pkg;
  typedef logic [7:0] psp_byte_type;
  typedef enum logic [1:0] {PSP_IDLE, PSP_WRITE, PSP_READ} psp_cycle_type;
endpackage

// ===== logic/psp_fifo_if.sv
// handshake bundle between the port logic and its receive fifo
`timescale 1ns/100ps
interface psp_fifo_if;
  psp_pkg::psp_byte_type in_data;
  logic                  in_valid;
  logic                  in_ready;
  psp_pkg::psp_byte_type out_data;
  logic                  out_valid;
  logic                  out_ready;
  modport fifo (input in_data, input in_valid, output in_ready,
                output out_data, output out_valid, input out_ready);
  modport user (output in_data, output in_valid, input in_ready,
                input out_data, input out_valid, output out_ready);
endinterface // psp_fifo_if

// ===== logic/psp_fifo.sv
// parameterised synchronous fifo for received bytes
`timescale 1ns/100ps
module psp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  psp_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  assign q.in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign q.out_valid = (count_ff != '0);
  assign q.out_data  = mem[rd_ptr_ff];
  assign push = q.in_valid && q.in_ready;
  assign pop  = q.out_valid && q.out_ready;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= q.in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (sys_rst)
    count_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // psp_fifo

// ===== logic/psp_slave_port.sv
// parallel slave port: strobe sync, cycle detect, flags and pin drive
// Functional notes
// - mode bit four selects slave port operation
// - control pins zero to two are strobes
// - write spans both strobes low until one high
// - write end latches byte, sets full, irq
// - read start drives latch, sets output full
// - write during read updates pins, not flag
// - read end tristates pins, sets irq
// - port only usable in microcontroller mode
// - write over unread byte sets sticky overflow
// - status read-only, except overflow cleared by writing bit 5 low; control resets to zero
`timescale 1ns/100ps
`include "psp_map.svh"
module psp_slave_port (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  read_strobe_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  chip_select_n,
  input  wire logic [7:0]            slave_data_in,
  output logic [7:0]                 slave_data_out,
  output logic                       slave_data_oe_n,
  input  wire logic [2:0]            strobe_port_direction,
  input  wire logic                  mcu_mode,
  input  wire logic                  ctl_wr,
  input  wire logic [7:0]            ctl_wdata,
  output logic [7:0]                 slave_port_control,
  input  wire logic                  data_wr,
  input  wire psp_pkg::psp_byte_type data_wdata,
  input  wire logic                  data_rd,
  output psp_pkg::psp_byte_type      data_rdata,
  output logic                       data_rvalid,
  output logic                       slave_port_irq_flag,
  input  wire logic                  irq_clr,
  output logic                       rx_ready
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0]            sync1_ff;
  logic [2:0]            sync2_ff;
  logic                  slave_port_mode_sel_ff;
  logic                  input_full_flag_ff;
  logic                  output_full_flag_ff;
  logic                  input_overflow_flag_ff;
  logic                  irq_ff;
  psp_pkg::psp_byte_type out_latch_ff;
  psp_pkg::psp_byte_type in_byte_ff;
  psp_pkg::psp_byte_type data_sync1_ff;
  psp_pkg::psp_byte_type data_sync2_ff;
  localparam logic [7:0] CTL_RESET_VAL = `PSP_CTL_RESET;
  psp_pkg::psp_cycle_type cyc_ff;
  psp_pkg::psp_cycle_type nxt_cyc;
  logic                  port_on;
  logic                  wr_low;
  logic                  rd_low;
  logic                  wr_end;
  logic                  rd_start;
  logic                  rd_end;
  psp_fifo_if            fq ();

  // ----------------------------------------
  // strobe synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      data_sync1_ff <= 8'h00;
      data_sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= {chip_select_n, write_strobe_n, read_strobe_n};
      sync2_ff <= sync1_ff;
      data_sync1_ff <= slave_data_in;
      data_sync2_ff <= data_sync1_ff;
    end
  end

  // port active only with mode set, inputs set, no ext bus
  assign port_on = slave_port_mode_sel_ff && mcu_mode && (&strobe_port_direction);
  assign wr_low  = !sync2_ff[`PSP_DIR_CS] && !sync2_ff[`PSP_DIR_WR];
  assign rd_low  = !sync2_ff[`PSP_DIR_CS] && !sync2_ff[`PSP_DIR_RD];

  // ----------------------------------------
  // cycle tracking
  // ----------------------------------------
  always_comb begin
    nxt_cyc = cyc_ff;
    unique case (cyc_ff)
      psp_pkg::PSP_IDLE: begin
        if (port_on && wr_low) begin
          nxt_cyc = psp_pkg::PSP_WRITE;
        end else if (port_on && rd_low) begin
          nxt_cyc = psp_pkg::PSP_READ;
        end
      end
      psp_pkg::PSP_WRITE: begin
        if (!wr_low) begin
          nxt_cyc = psp_pkg::PSP_IDLE;
        end
      end
      psp_pkg::PSP_READ: begin
        if (!rd_low) begin
          nxt_cyc = psp_pkg::PSP_IDLE;
        end
      end
    endcase
  end
  assign wr_end   = (cyc_ff == psp_pkg::PSP_WRITE) && !wr_low;
  assign rd_start = (cyc_ff == psp_pkg::PSP_IDLE) && port_on && !wr_low && rd_low;
  assign rd_end   = (cyc_ff == psp_pkg::PSP_READ) && !rd_low;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cyc_ff <= psp_pkg::PSP_IDLE;
    end else begin
      cyc_ff <= nxt_cyc;
    end
  end

  // ----------------------------------------
  // data latches
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      in_byte_ff <= 8'h00;
    end else if (cyc_ff == psp_pkg::PSP_WRITE && wr_low) begin
      in_byte_ff <= data_sync2_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_latch_ff <= 8'h00;
    end else if (data_wr) begin
      out_latch_ff <= data_wdata;
    end
  end

  assign fq.in_data  = in_byte_ff;
  assign fq.in_valid = wr_end;
  assign fq.out_ready = data_rd;
  assign rx_ready    = fq.in_ready;

  psp_fifo #(.WIDTH(`PSP_DATA_W), .DEPTH(`PSP_FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .q       (fq.fifo)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_rdata  <= 8'h00;
      data_rvalid <= 1'b0;
    end else begin
      data_rvalid <= data_rd && fq.out_valid;
      if (data_rd && fq.out_valid) begin
        data_rdata <= fq.out_data;
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign slave_data_out  = out_latch_ff;
  assign slave_data_oe_n = (cyc_ff != psp_pkg::PSP_READ);

  // ----------------------------------------
  // control and status flags
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slave_port_mode_sel_ff <= CTL_RESET_VAL[`PSP_CTL_MODE];
      input_overflow_flag_ff <= 1'b0;
    end else begin
      if (ctl_wr) begin
        slave_port_mode_sel_ff <= ctl_wdata[`PSP_CTL_MODE];
      end
      if (wr_end && fq.out_valid) begin
        input_overflow_flag_ff <= 1'b1;
      end else if (ctl_wr && !ctl_wdata[`PSP_CTL_OVF]) begin
        input_overflow_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      input_full_flag_ff <= 1'b0;
      output_full_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_end) begin
        input_full_flag_ff <= 1'b1;
      end else if (data_rd) begin
        input_full_flag_ff <= 1'b0;
      end
      if (rd_start) begin
        output_full_flag_ff <= 1'b1;
      end else if (data_wr && cyc_ff != psp_pkg::PSP_READ) begin
        output_full_flag_ff <= 1'b0;
      end
      if (wr_end || rd_end) begin
        irq_ff <= 1'b1;
      end else if (irq_clr) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // full status bits have no write path; overflow clears on a control write with bit 5 low
  assign slave_port_control = {input_full_flag_ff, output_full_flag_ff,
                               input_overflow_flag_ff, slave_port_mode_sel_ff, 4'h0};
  assign slave_port_irq_flag = irq_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wr_cycle;
    cyc_ff == psp_pkg::PSP_WRITE && !wr_low;
  endsequence
  a_write_end_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_wr_cycle |=> input_full_flag_ff && irq_ff) else $error("write end flags missing");
  a_read_end_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_end |=> irq_ff && slave_data_oe_n) else $error("read end not handled");
  a_read_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_start |=> !slave_data_oe_n && output_full_flag_ff) else $error("read not driven");
  a_read_new_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
    data_wr && cyc_ff == psp_pkg::PSP_READ && !rd_end |=> slave_data_out == $past(data_wdata)
      && output_full_flag_ff == $past(output_full_flag_ff)) else $error("read update wrong");
  a_mode_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !port_on && cyc_ff == psp_pkg::PSP_IDLE |=> cyc_ff == psp_pkg::PSP_IDLE)
    else $error("cycle without mode");
  a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    input_overflow_flag_ff && !ctl_wr |=> input_overflow_flag_ff) else $error("overflow lost");
  a_ovf_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_end && fq.out_valid |=> input_overflow_flag_ff) else $error("overflow not set");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(sync2_ff[`PSP_DIR_WR]) |-> $past(write_strobe_n, 2) == 1'b0)
    else $error("sync stage skipped");
  a_full_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    data_rd && !wr_end |=> !input_full_flag_ff) else $error("input full not cleared");
endmodule // psp_slave_port

// ===== testbench/psp_host_model.sv
// external processor model that drives the slave port strobes
`timescale 1ns/100ps
module psp_host_model (
  input  wire logic       sys_clk,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            chip_select_n,
  output logic [7:0]      host_data
);
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    host_data = 8'h00;
  end
  // one byte per strobe pair, strobes timed on falling edges of the device clock
  task automatic wr_cycle(input logic [7:0] b);
    @(negedge sys_clk);
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    host_data = b;
    repeat (6) @(negedge sys_clk);
    write_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    host_data = ~b;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic rd_start();
    @(negedge sys_clk);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic rd_end();
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (5) @(negedge sys_clk);
  endtask
endmodule // psp_host_model

// ===== testbench/testbench.sv
// self-checking bench of the parallel slave port
`timescale 1ns/100ps
module testbench;
  logic       sys_clk, sys_rst, rd_n, wr_n, cs_n, oe_n, mcu, irq, irq_clr, rx_ready;
  logic       ctl_wr, data_wr, data_rd, data_rvalid;
  logic [2:0] dir;
  logic [7:0] host_data, data_pin, data_out, ctl_wdata, ctl, data_wdata, data_rdata, v;
  logic [16:0] seed;
  int         err_count, compares, cycles, n;
  int         q[$];
  // ----------------------------------------
  // clock, pins and instances
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  assign data_pin = oe_n ? host_data : data_out;
  psp_host_model i_host (.sys_clk(sys_clk), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n), .host_data(host_data));
  psp_slave_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n), .slave_data_in(data_pin),
    .slave_data_out(data_out), .slave_data_oe_n(oe_n), .strobe_port_direction(dir),
    .mcu_mode(mcu), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .slave_port_control(ctl),
    .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
    .data_rdata(data_rdata), .data_rvalid(data_rvalid), .slave_port_irq_flag(irq),
    .irq_clr(irq_clr), .rx_ready(rx_ready));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic sw_ctl(input logic [7:0] x);
    @(negedge sys_clk) ctl_wr = 1'b1;
    ctl_wdata = x;
    @(negedge sys_clk) ctl_wr = 1'b0;
  endtask
  task automatic sw_wr(input logic [7:0] x);
    @(negedge sys_clk) data_wr = 1'b1;
    data_wdata = x;
    @(negedge sys_clk) data_wr = 1'b0;
  endtask
  task automatic sw_clr();
    @(negedge sys_clk) irq_clr = 1'b1;
    @(negedge sys_clk) irq_clr = 1'b0;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {ctl_wr, data_wr, data_rd, irq_clr, ctl_wdata, data_wdata} = '0;
    sys_rst = 1'b1;
    dir = 3'h7;
    mcu = 1'b1;
    seed = 17'h16F11;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(ctl, 8'h00);
    chk(oe_n, 8'h01);
    i_host.wr_cycle(8'h5A);
    chk(ctl, 8'h00);
    chk(irq, 8'h00);
    sw_ctl(8'hD0);
    chk(ctl, 8'h10);
    mcu = 1'b0;
    i_host.wr_cycle(8'hA5);
    chk(ctl, 8'h10);
    mcu = 1'b1;
    dir = 3'h3;
    i_host.wr_cycle(8'hC3);
    chk(ctl, 8'h10);
    chk(irq, 8'h00);
    dir = 3'h7;
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      i_host.wr_cycle(seed[7:0]);
      if (q.size() < 8) q.push_back(seed[7:0]);
      if (i == 0) begin
        chk(ctl, 8'h90);
        chk(irq, 8'h01);
        sw_clr();
      end
    end
    chk(rx_ready, 8'h00);
    chk(ctl[5], 8'h01);
    while (q.size() > 0) begin
      @(negedge sys_clk) data_rd = 1'b1;
      @(negedge sys_clk) data_rd = 1'b0;
      n = 0;
      while (data_rvalid !== 1'b1 && n < 4) begin
        @(negedge sys_clk);
        n++;
      end
      v = data_rdata;
      chk(v, q.pop_front());
    end
    chk(ctl[7], 8'h00);
    chk(rx_ready, 8'h01);
    sw_ctl(8'h10);
    chk(ctl[5], 8'h00);
    seed = lfsr(seed);
    sw_wr(seed[7:0]);
    sw_clr();
    i_host.rd_start();
    chk(oe_n, 8'h00);
    chk(data_pin, seed[7:0]);
    chk(ctl[6], 8'h01);
    sw_wr(~seed[7:0]);
    chk(data_pin, ~seed[7:0]);
    chk(ctl[6], 8'h01);
    i_host.rd_end();
    chk(oe_n, 8'h01);
    chk(irq, 8'h01);
    report_and_stop();
  end
endmodule // testbench
